// File: hw/rdimm_buf_cfg.svh
// Constants for the registering command and address buffer.
// Assumes one 50 MHz clock whose rising edge is the input clock crossing.
`ifndef RDIMM_BUF_CFG_SVH
`define RDIMM_BUF_CFG_SVH
`define ADDR_CMD_W     22
`define CTL_W          4
`define RANK_W         4
`define FIFO_DEPTH     16
`define CFG_ADDR_LSB   0
`define CFG_ADDR_W     4
`define CFG_DATA_LSB   4
`define CFG_DATA_W     4
`define CTL_RESET      4'h0
`define SEL_IDLE       4'hf
`define ERR_HOLD_NS    40
`define CLK_PERIOD_NS  20
`define ERR_HOLD_CYC   ((`ERR_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// File: hw/rdimm_buf_pkg.sv
// Types shared by the buffer modules.
// Assumes the constants header is compiled alongside.
package rdimm_buf_pkg;
  typedef enum logic [1:0] {
    chk_idle = 2'b00,
    chk_wait = 2'b01,
    chk_err  = 2'b10
  } chk_state_e;
endpackage

// File: hw/word_stream_if.sv
// Valid/ready carrier for words between buffer modules.
// Assumes a single clock domain.
`timescale 1ns/10ps
interface word_stream_if #(parameter int W = 8);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// File: hw/word_fifo.sv
// Synchronous FIFO with valid and ready on both sides.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module word_fifo #(
  parameter int W     = 8,
  parameter int DEPTH = 16
) (
  // Clock and reset
  input wire logic    ref_clk,
  input wire logic    nrst,
  // Streams
  word_stream_if.dst  wr,
  word_stream_if.src  rd
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW:0]  wp;
  logic [AW:0]  rp;
  logic [AW:0]  next_wp;
  logic [AW:0]  next_rp;
  logic         push;
  logic         pop;

  assign wr.ready = (wp - rp) != (AW+1)'(DEPTH);
  assign rd.valid = wp != rp;
  assign rd.data  = mem[rp[AW-1:0]];
  assign push     = wr.valid && wr.ready;
  assign pop      = rd.valid && rd.ready;

  always_comb begin
    next_wp = push ? wp + 1'b1 : wp;
    next_rp = pop ? rp + 1'b1 : rp;
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      wp <= '0;
      rp <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
    end
    if (push) begin
      mem[wp[AW-1:0]] <= wr.data;
    end
  end

  fifo_bound_a: assert property (@(posedge ref_clk) disable iff (!nrst)
    (wp - rp) <= (AW+1)'(DEPTH)) else $error("fifo over depth");
endmodule

// File: hw/parity_checker.sv
// Even parity check over selected command cycles.
// Assumes parity arrives one cycle after its command word.
`timescale 1ns/10ps
`include "rdimm_buf_cfg.svh"
module parity_checker #(
  parameter int W        = `ADDR_CMD_W,
  parameter int HOLD_CYC = `ERR_HOLD_CYC
) (
  // Clock and reset
  input  wire logic         ref_clk,
  input  wire logic         nrst,
  // Captured command cycle
  input  wire logic         cyc_sel,
  input  wire logic [W-1:0] cyc_bits,
  input  wire logic         parity_now,
  // Result
  output logic              mismatch
);
  logic                     pend;
  logic                     sum_lsb;
  logic                     next_pend;
  logic                     next_sum_lsb;
  logic                     next_mismatch;
  rdimm_buf_pkg::chk_state_e state;
  rdimm_buf_pkg::chk_state_e next_state;
  logic [3:0]               hold;
  logic [3:0]               next_hold;

  function automatic logic sum_bit(input logic [W-1:0] v);
    return ^v;
  endfunction

  always_comb begin
    next_pend    = cyc_sel;
    next_sum_lsb = sum_bit(cyc_bits);
    next_mismatch = pend && (sum_lsb != parity_now);
    next_state   = state;
    next_hold    = hold;
    case (state)
      rdimm_buf_pkg::chk_idle: begin
        if (next_mismatch) begin
          next_state = rdimm_buf_pkg::chk_err;
          next_hold  = 4'(HOLD_CYC);
        end
      end
      rdimm_buf_pkg::chk_err: begin
        if (next_mismatch) begin
          next_hold = 4'(HOLD_CYC);
        end else if (hold <= 4'h1) begin
          next_state = rdimm_buf_pkg::chk_idle;
          next_hold  = 4'h0;
        end else begin
          next_hold = hold - 4'h1;
        end
      end
      default: begin
        next_state = rdimm_buf_pkg::chk_idle;
        next_hold  = 4'h0;
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      pend    <= 1'b0;
      sum_lsb <= 1'b0;
      state   <= rdimm_buf_pkg::chk_idle;
      hold    <= 4'h0;
    end else begin
      pend    <= next_pend;
      sum_lsb <= next_sum_lsb;
      state   <= next_state;
      hold    <= next_hold;
    end
  end

  assign mismatch = state == rdimm_buf_pkg::chk_err;

  sequence sel_cycle;
    cyc_sel && (sum_bit(cyc_bits) == 1'b1);
  endsequence
  sequence wrong_par;
    !parity_now;
  endsequence
  par_flag_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) sel_cycle ##1 wrong_par |=> mismatch)
    else $error("missed parity error");
  good_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) sel_cycle ##1 parity_now |=> !$rose(mismatch))
    else $error("false parity error");
  no_sel_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) !cyc_sel |=> !pend)
    else $error("unselected cycle checked");
  unsel_quiet_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) !cyc_sel |=> ##1 !$rose(mismatch))
    else $error("unselected cycle flagged");
  flag_hold_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) $rose(mismatch) |-> mismatch[*2])
    else $error("error flag too short");
endmodule

// File: hw/rdimm_cmd_buffer.sv
// Registering command/address buffer with parity check for a memory module.
// Assumes all inputs except the mode strap are synchronous to ref_clk, the input clock crossing.
`timescale 1ns/10ps
`include "rdimm_buf_cfg.svh"
module rdimm_cmd_buffer #(
  parameter int AW = `ADDR_CMD_W,
  parameter int CW = `CTL_W
) (
  // Clock and reset
  input  wire logic          ref_clk,
  input  wire logic          nrst,
  // Mode strap, high for two-rank mode
  input  wire logic          quad_rank_select_enable_n,
  // Host command inputs
  input  wire logic [AW-1:0] addr_cmd_in,
  input  wire logic [1:0]    clock_enable_in,
  input  wire logic [1:0]    termination_ctl_in,
  input  wire logic [3:0]    rank_select_in,
  input  wire logic          cfg_access,
  input  wire logic          parity_in,
  // Redriven outputs
  output logic [AW-1:0]      addr_cmd_out_a,
  output logic [AW-1:0]      addr_cmd_out_b,
  output logic [1:0]         clock_enable_out,
  output logic [1:0]         termination_ctl_out,
  output logic [1:0]         clock_enable_out_b,
  output logic [1:0]         termination_ctl_out_b,
  output logic [1:0]         rank_select_out_a,
  output logic [1:0]         rank_select_out_b,
  output logic [3:0]         rank_select_out,
  output logic               out_valid,
  input  wire logic          out_ready,
  // Control register view
  output logic [CW-1:0]      ctl_reg_out,
  // Open-drain error pin
  output logic               parity_error_n_o,
  output logic               parity_error_n_oe
);
  localparam int WORD_W = AW + 8;
  logic [AW-1:0] cap_ac;
  logic [7:0]    cap_ctl;
  logic          cap_cfg;
  logic          cap_par;
  logic          cap_any;
  logic          quad_sync;
  logic          quad_mode;
  logic [CW-1:0] ctl_regs [4];
  logic [CW-1:0] next_ctl [4];
  logic          err;
  logic [WORD_W-1:0] out_word;

  word_stream_if #(.W(WORD_W)) to_fifo ();
  word_stream_if #(.W(WORD_W)) from_fifo ();

  // The mode strap is a board pin with no timing to ref_clk, so it passes two flops.
  // A strap change therefore takes effect two edges late.
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      cap_ac    <= '0;
      cap_ctl   <= {4'h0, `SEL_IDLE};
      cap_cfg   <= 1'b0;
      cap_par   <= 1'b0;
      quad_sync <= 1'b0;
      quad_mode <= 1'b0;
    end else begin
      cap_ac    <= addr_cmd_in;
      cap_ctl   <= {clock_enable_in, termination_ctl_in, rank_select_in};
      cap_cfg   <= cfg_access;
      cap_par   <= parity_in;
      quad_sync <= !quad_rank_select_enable_n;
      quad_mode <= quad_sync;
    end
  end

  // Low select means selected; in two-rank mode only the lower two count.
  assign cap_any = quad_mode ? (cap_ctl[3:0] != 4'hf) : (cap_ctl[1:0] != 2'h3);

  always_comb begin
    for (int i = 0; i < 4; i++) begin
      next_ctl[i] = ctl_regs[i];
    end
    if (cap_cfg && cap_any) begin
      next_ctl[cap_ac[`CFG_ADDR_LSB +: 2]] = cap_ac[`CFG_DATA_LSB +: CW];
    end
  end

  always_ff @(posedge ref_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (!nrst) begin
        ctl_regs[i] <= `CTL_RESET;
      end else begin
        ctl_regs[i] <= next_ctl[i];
      end
    end
  end
  assign ctl_reg_out = ctl_regs[0];

  // Configuration words stop here, and so do deselected cycles: they carry no command,
  // and queuing them would fill the buffer and squeeze out the commands behind them.
  assign to_fifo.valid = !cap_cfg && cap_any;
  assign to_fifo.data  = {cap_ctl, cap_ac};

  word_fifo #(.W(WORD_W), .DEPTH(`FIFO_DEPTH)) u_fifo (
    .ref_clk (ref_clk),
    .nrst    (nrst),
    .wr      (to_fifo),
    .rd      (from_fifo)
  );

  assign from_fifo.ready = out_ready;
  assign out_valid       = from_fifo.valid;
  assign out_word        = from_fifo.data;

  // Data is held in the FIFO register array; both copies come from one word.
  always_comb begin
    addr_cmd_out_a      = out_word[AW-1:0];
    addr_cmd_out_b      = out_word[AW-1:0];
    clock_enable_out      = out_word[AW+7 -: 2];
    clock_enable_out_b    = out_word[AW+7 -: 2];
    termination_ctl_out   = out_word[AW+5 -: 2];
    termination_ctl_out_b = out_word[AW+5 -: 2];
    if (quad_mode) begin
      rank_select_out   = out_word[AW+3 -: 4];
      rank_select_out_a = 2'h3;
      rank_select_out_b = 2'h3;
    end else begin
      rank_select_out   = `SEL_IDLE;
      rank_select_out_a = out_word[AW+1 -: 2];
      rank_select_out_b = out_word[AW+1 -: 2];
    end
  end

  // Only address and command bits enter the sum.
  parity_checker #(.W(AW)) u_par (
    .ref_clk    (ref_clk),
    .nrst       (nrst),
    .cyc_sel    (cap_any),
    .cyc_bits   (cap_ac),
    .parity_now (cap_par),
    .mismatch   (err)
  );

  assign parity_error_n_o  = 1'b0;
  assign parity_error_n_oe = err;

  copy_match_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) addr_cmd_out_a == addr_cmd_out_b)
    else $error("copies differ");
  ctl_copy_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    clock_enable_out == clock_enable_out_b && termination_ctl_out == termination_ctl_out_b)
    else $error("control copies differ");
  quad_idle_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) quad_mode |-> rank_select_out_a == 2'h3)
    else $error("A selects active");
  quad_b_idle_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) quad_mode |-> rank_select_out_b == 2'h3)
    else $error("B selects active");
  dual_idle_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) !quad_mode |-> rank_select_out == `SEL_IDLE)
    else $error("quad selects active");
  sel_copy_a: assert property (
    @(posedge ref_clk) disable iff (!nrst)
    !quad_mode |-> rank_select_out_a == rank_select_out_b)
    else $error("select copies differ");
  cfg_block_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) cap_cfg |-> !to_fifo.valid)
    else $error("config word redriven");
  push_gate_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) to_fifo.valid |-> cap_any)
    else $error("deselected word queued");
  capture_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) 1'b1 |=> cap_ac == $past(addr_cmd_in))
    else $error("input not captured");
  err_pin_a: assert property (
    @(posedge ref_clk) disable iff (!nrst) err |-> parity_error_n_oe && !parity_error_n_o)
    else $error("error pin idle");
endmodule

// File: verification/host_cmd_model.sv
// Host controller model driving command words with trailing parity.
// Assumes the bench calls its tasks one after another on ref_clk.
`timescale 1ns/10ps
module host_cmd_model (
  // Clock
  input  wire logic   ref_clk,
  // Command bus toward the buffer
  output logic [21:0] addr_cmd_in,
  output logic [3:0]  rank_select_in,
  output logic        cfg_access,
  output logic        parity_in
);
  logic pend;
  initial begin
    addr_cmd_in    = 22'h0;
    rank_select_in = 4'hf;
    cfg_access     = 1'b0;
    parity_in      = 1'b0;
    pend           = 1'b0;
  end
  // Parity always trails its word by one cycle, so back-to-back sends pipeline it.
  task automatic send(input logic [21:0] w, input logic [3:0] s, input logic bad,
                      input logic cfg);
    @(negedge ref_clk);
    parity_in      <= pend;
    addr_cmd_in    <= w;
    rank_select_in <= s;
    cfg_access     <= cfg;
    pend            = ^w ^ bad;
  endtask
  task automatic idle();
    @(negedge ref_clk);
    parity_in      <= pend;
    addr_cmd_in    <= ~addr_cmd_in;
    rank_select_in <= 4'hf;
    cfg_access     <= 1'b0;
    pend            = ^(~addr_cmd_in);
  endtask
endmodule

// File: verification/testbench.sv
// Self-checking bench for the registering command buffer.
// Assumes the host model drives the command bus on falling edges.
`timescale 1ns/10ps
module testbench;
  logic        ref_clk, nrst, qmode_n, out_ready, out_valid;
  logic        cfg_access, parity_in, err_o, err_oe, err_pin;
  logic [21:0] addr_cmd_in, out_a, out_b;
  logic [3:0]  sel_in, sel_q, ctl;
  logic [1:0]  ce, odt, ce_q, odt_q, ce_b, odt_b, sel_a, sel_b;
  int          err_count, n_compared;
  assign err_pin = err_oe ? err_o : 1'b1;
  host_cmd_model i_host_cmd_model (.ref_clk(ref_clk), .addr_cmd_in(addr_cmd_in),
    .rank_select_in(sel_in), .cfg_access(cfg_access), .parity_in(parity_in));
  rdimm_cmd_buffer i_rdimm_cmd_buffer (.ref_clk(ref_clk), .nrst(nrst),
    .quad_rank_select_enable_n(qmode_n), .addr_cmd_in(addr_cmd_in),
    .clock_enable_in(ce), .termination_ctl_in(odt), .rank_select_in(sel_in),
    .cfg_access(cfg_access), .parity_in(parity_in), .addr_cmd_out_a(out_a),
    .addr_cmd_out_b(out_b), .clock_enable_out(ce_q), .termination_ctl_out(odt_q),
    .clock_enable_out_b(ce_b), .termination_ctl_out_b(odt_b),
    .rank_select_out_a(sel_a), .rank_select_out_b(sel_b), .rank_select_out(sel_q),
    .out_valid(out_valid), .out_ready(out_ready), .ctl_reg_out(ctl),
    .parity_error_n_o(err_o), .parity_error_n_oe(err_oe));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = ~ref_clk;
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [21:0] e, input logic [21:0] g);
    n_compared++;
    if (g !== e) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pop(input logic [21:0] w, input logic [1:0] ra, input logic [3:0] rq,
                     input logic [1:0] c, input logic [1:0] o);
    for (int i = 0; i < 8 && out_valid !== 1'b1; i++) @(negedge ref_clk);
    chk("out_valid", 1, out_valid);
    chk("copy_a", w, out_a);
    chk("copy_b", w, out_b);
    chk("sel_a", ra, sel_a);
    chk("sel_b", ra, sel_b);
    chk("sel_q", rq, sel_q);
    chk("ce_q", c, ce_q);
    chk("ce_b", c, ce_b);
    chk("odt_q", o, odt_q);
    chk("odt_b", o, odt_b);
    out_ready <= 1'b1;
    @(negedge ref_clk);
    out_ready <= 1'b0;
    @(negedge ref_clk);
  endtask
  task automatic err_watch(input string n, input logic e);
    logic seen;
    seen = 1'b0;
    for (int i = 0; i < 6; i++) begin
      @(negedge ref_clk);
      if (err_pin === 1'b0) seen = 1'b1;
    end
    chk(n, e, seen);
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic t_two();
    i_host_cmd_model.send(22'h2aaaa5, 4'he, 1'b0, 1'b0);
    i_host_cmd_model.idle();
    err_watch("good_par", 1'b0);
    pop(22'h2aaaa5, 2'b10, 4'hf, 2'b01, 2'b10);
    $display("done two_rank");
  endtask
  task automatic t_quad();
    qmode_n <= 1'b0;
    i_host_cmd_model.send(22'h155555, 4'h7, 1'b0, 1'b0);
    i_host_cmd_model.idle();
    pop(22'h155555, 2'h3, 4'h7, 2'b01, 2'b10);
    qmode_n <= 1'b1;
    $display("done quad_rank");
  endtask
  task automatic t_perr();
    i_host_cmd_model.send(22'h000001, 4'he, 1'b1, 1'b0);
    i_host_cmd_model.idle();
    err_watch("bad_par", 1'b1);
    i_host_cmd_model.send(22'h000003, 4'hf, 1'b1, 1'b0);
    i_host_cmd_model.idle();
    err_watch("unsel_par", 1'b0);
    out_ready <= 1'b1;
    repeat (20) @(negedge ref_clk);
    out_ready <= 1'b0;
    $display("done parity");
  endtask
  task automatic t_excl();
    for (int i = 0; i < 4; i++) begin
      i_host_cmd_model.send(22'h000100 + 22'(i), 4'hd, 1'b0, 1'b0);
      // Control bits have odd parity every cycle, so counting them would raise the flag.
      ce  <= 2'(i);
      odt <= 2'(i) ^ 2'h1;
    end
    i_host_cmd_model.idle();
    err_watch("ctl_excl", 1'b0);
    for (int i = 0; i < 4; i++) begin
      pop(22'h000100 + 22'(i), 2'b01, 4'hf, 2'(i), 2'(i) ^ 2'h1);
    end
    $display("done excl");
  endtask
  task automatic t_cfg();
    i_host_cmd_model.send(22'h000050, 4'he, 1'b0, 1'b1);
    i_host_cmd_model.idle();
    repeat (4) @(negedge ref_clk);
    chk("ctl_reg", 22'h5, 22'(ctl));
    chk("cfg_no_out", 0, out_valid);
    $display("done cfg");
  endtask
  task automatic t_fifo();
    for (int i = 0; i < 17; i++) i_host_cmd_model.send(22'(i + 16), 4'he, 1'b0, 1'b0);
    i_host_cmd_model.idle();
    for (int i = 0; i < 16; i++) pop(22'(i + 16), 2'b10, 4'hf, 2'b11, 2'b10);
    repeat (3) @(negedge ref_clk);
    chk("fifo_empty", 0, out_valid);
    $display("done fifo");
  endtask
  initial begin
    #300us;
    err_count++;
    test_done();
  end
  initial begin
    err_count  = 0;
    n_compared = 0;
    nrst       = 1'b0;
    qmode_n    = 1'b1;
    out_ready  = 1'b0;
    ce         = 2'b01;
    odt        = 2'b10;
    repeat (12) @(negedge ref_clk);
    nrst <= 1'b1;
    @(negedge ref_clk);
    t_two();
    t_quad();
    t_perr();
    t_excl();
    t_cfg();
    t_fifo();
    test_done();
  end
endmodule
